// ==== hdl/atrb_cfg.svh ====
// Summary of operation
// - Core B first input gets its offset trim
// - Core B second input gets its offset trim
// - Dual mode: four separate bank gain trims
// - Single mode: core A bank0 own gain
// - Trims preload from fuse store
`ifndef ATRB_CFG_SVH
`define ATRB_CFG_SVH

// Register indices; byte address is four times the index
`define ATRB_IDX_OFS_B_IN1  12'h34c
`define ATRB_IDX_OFS_B_IN2  12'h34e
`define ATRB_IDX_GAIN_A0    12'h350
`define ATRB_IDX_GAIN_A1    12'h351
`define ATRB_IDX_GAIN_B0    12'h352
`define ATRB_IDX_GAIN_B1    12'h353
`define ATRB_IDX_GAIN_A0_S  12'h354
`define ATRB_IDX_CTRL       12'h360
`define ATRB_IDX_STAT       12'h361

// Trim entry numbers in the bank
`define ATRB_ENT_OFS_B_IN1  3'h0
`define ATRB_ENT_OFS_B_IN2  3'h1
`define ATRB_ENT_GAIN_A0    3'h2
`define ATRB_ENT_GAIN_A1    3'h3
`define ATRB_ENT_GAIN_B0    3'h4
`define ATRB_ENT_GAIN_B1    3'h5
`define ATRB_ENT_GAIN_A0_S  3'h6
`define ATRB_NUM_TRIM       7
`define ATRB_LAST_ENT       3'h6

// Field layout
`define ATRB_OFS_MSB        11
`define ATRB_GAIN_MSB       4
`define ATRB_OFS_MASK       16'hffff
`define ATRB_GAIN_MASK      16'h00ff
`define ATRB_CTRL_FG_BIT    0
`define ATRB_CTRL_SGL_BIT   1
`define ATRB_STAT_LOAD_BIT  0

// Reset values
`define ATRB_TRIM_RST       16'h0000
`define ATRB_CTRL_RST       2'h0

// Factory fuse contents; values are arbitrary
`define ATRB_FUSE_V0        16'h0812
`define ATRB_FUSE_V1        16'h07e9
`define ATRB_FUSE_V2        16'h0011
`define ATRB_FUSE_V3        16'h000e
`define ATRB_FUSE_V4        16'h0013
`define ATRB_FUSE_V5        16'h000c
`define ATRB_FUSE_V6        16'h0015

`endif

// ==== hdl/atrb_pkg.sv ====
`default_nettype none
package atrb_pkg;
   // Fuse preload sequencer states
   typedef enum logic [2:0] {
      ATRB_ST_ADDR  = 3'b001,
      ATRB_ST_CAPT  = 3'b010,
      ATRB_ST_READY = 3'b100
   } atrb_state_t;

   typedef logic [15:0] atrb_word_t;
endpackage
`default_nettype wire

// ==== hdl/atrb_fuse_rom.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "atrb_cfg.svh"
module atrb_fuse_rom #(
   parameter int DEPTH = `ATRB_NUM_TRIM,
   parameter int AW    = 3
) (
   input  wire logic          clk_i,   // System clock
   input  wire logic [AW-1:0] addr_i,  // Fuse word index
   output var  logic [15:0]   data_o   // Registered fuse word
);
   // Refuse a table that the index cannot reach
   if (DEPTH > (1 << AW) || DEPTH != `ATRB_NUM_TRIM)
   begin : g_bad_depth
      $error("atrb_fuse_rom: depth does not fit");
   end

   logic [15:0] data_next;

   // Constant factory table
   always_comb
   begin
      case (addr_i)
         `ATRB_ENT_OFS_B_IN1: data_next = `ATRB_FUSE_V0;
         `ATRB_ENT_OFS_B_IN2: data_next = `ATRB_FUSE_V1;
         `ATRB_ENT_GAIN_A0:   data_next = `ATRB_FUSE_V2;
         `ATRB_ENT_GAIN_A1:   data_next = `ATRB_FUSE_V3;
         `ATRB_ENT_GAIN_B0:   data_next = `ATRB_FUSE_V4;
         `ATRB_ENT_GAIN_B1:   data_next = `ATRB_FUSE_V5;
         `ATRB_ENT_GAIN_A0_S: data_next = `ATRB_FUSE_V6;
         default:             data_next = 16'h0000;
      endcase
   end

   // Read data register
   always_ff @(posedge clk_i)
   begin
      data_o <= data_next;
   end
endmodule
`default_nettype wire

// ==== hdl/atrb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "atrb_cfg.svh"
module atrb_top (
   input  wire logic        clk_i,              // 40 MHz clock
   input  wire logic        rst_i,              // Sync reset, active high
   input  wire logic        wb_cyc_i,           // Wishbone cycle
   input  wire logic        wb_stb_i,           // Wishbone strobe
   input  wire logic        wb_we_i,            // Wishbone write enable
   input  wire logic [13:0] wb_adr_i,           // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,           // Wishbone byte lanes
   input  wire logic [31:0] wb_dat_i,           // Wishbone write data
   output var  logic [31:0] wb_dat_o,           // Wishbone read data
   output var  logic        wb_ack_o,           // Wishbone acknowledge
   input  wire logic        core_b_input_sel_i, // Core B samples: 0 first, 1 second
   output var  logic [11:0] offset_b_o,         // Applied core B offset trim
   output var  logic [4:0]  gain_a0_o,          // Applied core A bank 0 gain
   output var  logic [4:0]  gain_a1_o,          // Applied core A bank 1 gain
   output var  logic [4:0]  gain_b0_o,          // Applied core B bank 0 gain
   output var  logic [4:0]  gain_b1_o,          // Applied core B bank 1 gain
   output var  logic        fuse_loaded_o       // Preload finished
);
   atrb_pkg::atrb_state_t state_reg;
   atrb_pkg::atrb_state_t state_next;
   logic [2:0]             load_idx_reg;
   logic [2:0]             load_idx_next;
   logic [15:0]            fuse_data;
   logic                   capture;
   atrb_pkg::atrb_word_t   trim_reg  [`ATRB_NUM_TRIM];
   atrb_pkg::atrb_word_t   trim_next [`ATRB_NUM_TRIM];
   logic [1:0]             ctrl_reg;
   logic [1:0]             ctrl_next;
   logic                   ack_reg;
   logic                   ack_next;
   logic [31:0]            dat_reg;
   logic [31:0]            dat_next;
   logic [11:0]            idx;
   logic                   hit_trim;
   logic                   hit_ctrl;
   logic                   hit_stat;
   logic [2:0]             hit_ent;
   logic                   req;
   logic                   wr_en;
   logic [15:0]            lane_mask;
   logic [15:0]            rd_word;
   logic                   fg_en;
   logic                   single_mode;
   logic [11:0]            offset_next;
   logic [4:0]             gain_a0_next;
   logic [4:0]             gain_a1_next;
   logic [4:0]             gain_b0_next;
   logic [4:0]             gain_b1_next;

   // Factory fuse store
   atrb_fuse_rom #(
      .DEPTH (`ATRB_NUM_TRIM),
      .AW    (3)
   ) i_atrb_fuse_rom (
      .clk_i  (clk_i),
      .addr_i (load_idx_reg),
      .data_o (fuse_data)
   );

   // Preload sequencer: address, then capture, for each entry
   always_comb
   begin
      state_next    = state_reg;
      load_idx_next = load_idx_reg;
      capture       = 1'b0;
      case (state_reg)
         atrb_pkg::ATRB_ST_ADDR:
            state_next = atrb_pkg::ATRB_ST_CAPT;
         atrb_pkg::ATRB_ST_CAPT:
         begin
            capture = 1'b1;
            if (load_idx_reg == `ATRB_LAST_ENT)
               state_next = atrb_pkg::ATRB_ST_READY;
            else
            begin
               load_idx_next = load_idx_reg + 3'h1;
               state_next    = atrb_pkg::ATRB_ST_ADDR;
            end
         end
         atrb_pkg::ATRB_ST_READY:
            state_next = atrb_pkg::ATRB_ST_READY;
         default:
            state_next = atrb_pkg::ATRB_ST_ADDR;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg    <= atrb_pkg::ATRB_ST_ADDR;
         load_idx_reg <= 3'h0;
      end
      else
      begin
         state_reg    <= state_next;
         load_idx_reg <= load_idx_next;
      end
   end

   // Address decode on word index
   always_comb
   begin
      idx      = wb_adr_i[13:2];
      hit_trim = 1'b1;
      hit_ctrl = 1'b0;
      hit_stat = 1'b0;
      hit_ent  = 3'h0;
      if (idx == `ATRB_IDX_OFS_B_IN1)
         hit_ent = `ATRB_ENT_OFS_B_IN1;
      else if (idx == `ATRB_IDX_OFS_B_IN2)
         hit_ent = `ATRB_ENT_OFS_B_IN2;
      else if (idx == `ATRB_IDX_GAIN_A0)
         hit_ent = `ATRB_ENT_GAIN_A0;
      else if (idx == `ATRB_IDX_GAIN_A1)
         hit_ent = `ATRB_ENT_GAIN_A1;
      else if (idx == `ATRB_IDX_GAIN_B0)
         hit_ent = `ATRB_ENT_GAIN_B0;
      else if (idx == `ATRB_IDX_GAIN_B1)
         hit_ent = `ATRB_ENT_GAIN_B1;
      else if (idx == `ATRB_IDX_GAIN_A0_S)
         hit_ent = `ATRB_ENT_GAIN_A0_S;
      else
      begin
         hit_trim = 1'b0;
         if (idx == `ATRB_IDX_CTRL)
            hit_ctrl = 1'b1;
         else if (idx == `ATRB_IDX_STAT)
            hit_stat = 1'b1;
      end
   end

   // Bus request, write strobe and byte lanes
   assign req       = wb_cyc_i & wb_stb_i;
   assign wr_en     = req & wb_we_i & ack_reg;
   assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Per-entry trim storage: fuse capture, then lane-masked writes
   for (genvar i = 0; i < `ATRB_NUM_TRIM; i++)
   begin : g_trim
      localparam logic [15:0] MASK = (i < 2) ? `ATRB_OFS_MASK : `ATRB_GAIN_MASK;
      always_comb
      begin
         trim_next[i] = trim_reg[i];
         if (capture && load_idx_reg == 3'(i))
            trim_next[i] = fuse_data & MASK;
         else if (wr_en && hit_trim && hit_ent == 3'(i))
            trim_next[i] = ((trim_reg[i] & ~lane_mask)
                           | (wb_dat_i[15:0] & lane_mask)) & MASK;
      end

      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            trim_reg[i] <= `ATRB_TRIM_RST;
         else
            trim_reg[i] <= trim_next[i];
      end
   end

   // Control register, read mux and acknowledge
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (wr_en && hit_ctrl && wb_sel_i[0])
         ctrl_next = wb_dat_i[1:0];
      rd_word = 16'h0000;
      if (hit_trim)
         rd_word = trim_reg[hit_ent];
      else if (hit_ctrl)
         rd_word = {14'h0000, ctrl_reg};
      else if (hit_stat)
         rd_word = {15'h0000, fuse_loaded_o};
      ack_next = req & ~ack_reg & (state_reg == atrb_pkg::ATRB_ST_READY);
      dat_next = ack_next ? {16'h0000, rd_word} : 32'h0000_0000;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_reg <= `ATRB_CTRL_RST;
         ack_reg  <= 1'b0;
         dat_reg  <= 32'h0000_0000;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         ack_reg  <= ack_next;
         dat_reg  <= dat_next;
      end
   end

   assign wb_ack_o    = ack_reg;
   assign wb_dat_o    = dat_reg;
   assign fg_en       = ctrl_reg[`ATRB_CTRL_FG_BIT];
   assign single_mode = ctrl_reg[`ATRB_CTRL_SGL_BIT];

   // Applied trims, gated by foreground calibration
   always_comb
   begin
      offset_next  = 12'h000;
      gain_a0_next = 5'h00;
      gain_a1_next = 5'h00;
      gain_b0_next = 5'h00;
      gain_b1_next = 5'h00;
      if (fg_en)
      begin
         if (core_b_input_sel_i)
            offset_next = trim_reg[`ATRB_ENT_OFS_B_IN2][`ATRB_OFS_MSB:0];
         else
            offset_next = trim_reg[`ATRB_ENT_OFS_B_IN1][`ATRB_OFS_MSB:0];
         if (single_mode)
            gain_a0_next = trim_reg[`ATRB_ENT_GAIN_A0_S][`ATRB_GAIN_MSB:0];
         else
            gain_a0_next = trim_reg[`ATRB_ENT_GAIN_A0][`ATRB_GAIN_MSB:0];
         gain_a1_next = trim_reg[`ATRB_ENT_GAIN_A1][`ATRB_GAIN_MSB:0];
         gain_b0_next = trim_reg[`ATRB_ENT_GAIN_B0][`ATRB_GAIN_MSB:0];
         gain_b1_next = trim_reg[`ATRB_ENT_GAIN_B1][`ATRB_GAIN_MSB:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         offset_b_o    <= 12'h000;
         gain_a0_o     <= 5'h00;
         gain_a1_o     <= 5'h00;
         gain_b0_o     <= 5'h00;
         gain_b1_o     <= 5'h00;
         fuse_loaded_o <= 1'b0;
      end
      else
      begin
         offset_b_o    <= offset_next;
         gain_a0_o     <= gain_a0_next;
         gain_a1_o     <= gain_a1_next;
         gain_b0_o     <= gain_b0_next;
         gain_b1_o     <= gain_b1_next;
         fuse_loaded_o <= (state_next == atrb_pkg::ATRB_ST_READY);
      end
   end

   // Checks on applied trims and preload
   a_offset_in1: assert property (@(posedge clk_i) disable iff (rst_i)
      fg_en && !core_b_input_sel_i |=>
         offset_b_o == $past(trim_reg[`ATRB_ENT_OFS_B_IN1][`ATRB_OFS_MSB:0]))
      else $error("core B first input offset not applied");

   a_offset_in2: assert property (@(posedge clk_i) disable iff (rst_i)
      fg_en && core_b_input_sel_i |=>
         offset_b_o == $past(trim_reg[`ATRB_ENT_OFS_B_IN2][`ATRB_OFS_MSB:0]))
      else $error("core B second input offset not applied");

   a_gain_dual: assert property (@(posedge clk_i) disable iff (rst_i)
      fg_en && !single_mode |=>
         gain_a0_o == $past(trim_reg[`ATRB_ENT_GAIN_A0][`ATRB_GAIN_MSB:0])
         && gain_b1_o == $past(trim_reg[`ATRB_ENT_GAIN_B1][`ATRB_GAIN_MSB:0]))
      else $error("dual mode gain trims not applied");

   a_gain_single: assert property (@(posedge clk_i) disable iff (rst_i)
      fg_en && single_mode |=>
         gain_a0_o == $past(trim_reg[`ATRB_ENT_GAIN_A0_S][`ATRB_GAIN_MSB:0]))
      else $error("single mode bank 0 gain not applied");

   a_fuse_value: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(fuse_loaded_o) |->
         trim_reg[`ATRB_ENT_OFS_B_IN1] == `ATRB_FUSE_V0
         && trim_reg[`ATRB_ENT_GAIN_A0_S] == `ATRB_FUSE_V6)
      else $error("fuse preload values wrong");

   a_fuse_time: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> !fuse_loaded_o [*8] ##[1:8] fuse_loaded_o)
      else $error("fuse preload not finished in time");

   a_offset_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !fg_en |=> offset_b_o == 12'h000)
      else $error("offset applied without foreground calibration");

   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
endmodule
`default_nettype wire

// ==== test/atrb_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "atrb_cfg.svh"
module atrb_top_tb;
   typedef struct packed
   {
      logic [31:0] val;
      logic        chk;
   } atrb_note_t;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, core_b_input_sel_i, probe;
   logic [13:0] wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        wb_ack_o, fuse_loaded_o;
   logic [11:0] offset_b_o;
   logic [4:0]  gain_a0_o, gain_a1_o, gain_b0_o, gain_b1_o;
   logic [15:0] trim_m [0:6];
   logic [15:0] fuse_tab [0:6];
   logic [11:0] idx_tab [0:6];
   logic [1:0]  ctrl_m;
   atrb_note_t  rq [$];
   logic [31:0] tq [$];
   atrb_note_t  note;
   int          fails, check_count, k, m, v;

   atrb_top i_atrb_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_b_input_sel_i(core_b_input_sel_i),
      .offset_b_o(offset_b_o), .gain_a0_o(gain_a0_o), .gain_a1_o(gain_a1_o),
      .gain_b0_o(gain_b0_o), .gain_b1_o(gain_b1_o), .fuse_loaded_o(fuse_loaded_o));

   // Clock, 25 ns period
   initial
   begin
      clk_i = 1'h0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Compare one value against its note
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One classic Wishbone cycle, waits for ack under a bound
   task automatic bus(input logic w, input logic [11:0] ix, input logic [3:0] s,
                      input logic [31:0] d, input logic [31:0] e, input logic c);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= w;
      wb_adr_i <= {ix, 2'h0};
      wb_sel_i <= s;
      wb_dat_i <= d;
      rq.push_back('{val: e, chk: c});
      for (n = 0; n < 60; n++)
      begin
         @(posedge clk_i);
         if (wb_ack_o === 1'h1)
            break;
      end
      if (n >= 60)
      begin
         fails++;
         report_and_stop();
      end
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask

   // Write and track the register model, lane by lane
   task automatic wr(input logic [11:0] ix, input logic [3:0] s, input logic [31:0] d);
      bus(1'h1, ix, s, d, 32'h0, 1'h0);
      for (int j = 0; j < 7; j++)
      begin
         if (idx_tab[j] == ix && s[0])
            trim_m[j][7:0] = d[7:0];
         if (idx_tab[j] == ix && s[1] && j < 2)
            trim_m[j][15:8] = d[15:8];
      end
      if (ix == `ATRB_IDX_CTRL && s[0])
         ctrl_m = d[1:0];
   endtask

   task automatic rd(input logic [11:0] ix, input logic [31:0] e);
      bus(1'h0, ix, 4'hf, $urandom, e, 1'h1);
   endtask

   // Expected applied trims, packed like the monitor's view
   function automatic logic [31:0] exp_trims();
      logic [4:0] a0;
      a0 = ctrl_m[1] ? trim_m[6][4:0] : trim_m[2][4:0];
      if (ctrl_m[0] !== 1'h1)
         return 32'h0;
      return {(core_b_input_sel_i ? trim_m[1][11:0] : trim_m[0][11:0]), a0,
              trim_m[3][4:0], trim_m[4][4:0], trim_m[5][4:0]};
   endfunction

   // Let trims settle, then ask the monitor to compare
   task automatic probe_trims(input logic s);
      @(posedge clk_i);
      core_b_input_sel_i <= s;
      repeat (3) @(posedge clk_i);
      tq.push_back(exp_trims());
      probe <= 1'h1;
      @(posedge clk_i);
      probe <= 1'h0;
   endtask

   task automatic reset_dut();
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      trim_m = fuse_tab;
      ctrl_m = 2'h0;
   endtask

   // Monitor: pops the oldest note whenever a result appears
   always @(posedge clk_i)
   begin
      if (wb_ack_o === 1'h1 && rq.size() > 0)
      begin
         note = rq.pop_front();
         if (note.chk)
            check("wb_dat_o", wb_dat_o, note.val);
      end
      if (probe === 1'h1 && tq.size() > 0)
         check("trims", {offset_b_o, gain_a0_o, gain_a1_o, gain_b0_o, gain_b1_o},
               tq.pop_front());
      // Every probe comes after preload, so the done flag must stand
      if (probe === 1'h1)
         check("fuse_loaded_o", {31'h0, fuse_loaded_o}, 32'h1);
   end

   // Main sequence
   initial
   begin
      rst_i = 1'h1;
      wb_cyc_i = 1'h0;
      wb_stb_i = 1'h0;
      wb_we_i = 1'h0;
      wb_adr_i = 14'h0;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      core_b_input_sel_i = 1'h0;
      probe = 1'h0;
      void'($urandom(34714));
      fuse_tab = '{`ATRB_FUSE_V0, `ATRB_FUSE_V1, `ATRB_FUSE_V2, `ATRB_FUSE_V3,
                   `ATRB_FUSE_V4, `ATRB_FUSE_V5, `ATRB_FUSE_V6};
      idx_tab = '{`ATRB_IDX_OFS_B_IN1, `ATRB_IDX_OFS_B_IN2, `ATRB_IDX_GAIN_A0,
                  `ATRB_IDX_GAIN_A1, `ATRB_IDX_GAIN_B0, `ATRB_IDX_GAIN_B1, `ATRB_IDX_GAIN_A0_S};
      for (m = 0; m < 2; m++)
      begin
         reset_dut();
         // Issued during preload; answered once the fuse copy is in
         rd(`ATRB_IDX_STAT, 32'h1);
         for (k = 0; k < 7; k++)
            rd(idx_tab[k], {16'h0, trim_m[k]});
         for (v = 0; v < 2; v++)
            probe_trims(v[0]);
         // Control modes 1 to 3, both inputs of core B
         for (k = 1; k < 4; k++)
            for (v = 0; v < 2; v++)
            begin
               wr(`ATRB_IDX_CTRL, 4'h1, k);
               probe_trims(v[0]);
            end
         // Random trims, reserved bits read back as written except gain bits 15:8, which read as zero
         for (k = 0; k < 7; k++)
         begin
            wr(idx_tab[k], 4'h3, $urandom);
            rd(idx_tab[k], {16'h0, trim_m[k]});
         end
         probe_trims(1'h0);
         probe_trims(1'h1);
         // Single byte lanes, then fg off with written values
         wr(idx_tab[0], 4'h1, $urandom);
         wr(idx_tab[1], 4'h2, $urandom);
         rd(idx_tab[0], {16'h0, trim_m[0]});
         rd(idx_tab[1], {16'h0, trim_m[1]});
         wr(`ATRB_IDX_CTRL, 4'h1, 32'h2);
         probe_trims(1'h1);
         // Unmapped gap and read-only status
         wr(12'h34d, 4'hf, $urandom);
         rd(12'h34d, 32'h0);
         wr(`ATRB_IDX_STAT, 4'hf, 32'h0);
         rd(`ATRB_IDX_STAT, 32'h1);
         rd(idx_tab[0], {16'h0, trim_m[0]});
         wr(`ATRB_IDX_CTRL, 4'h1, 32'h3);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
